//--- pkg/ueb_pkg.sv
// Package with the constants and types of the endpoint register block.
package ueb_pkg;

   localparam int EP_NUM     = 5;
   localparam int BANK_DEPTH = 64;

   // Register offsets on the byte-wide register port.
   localparam logic [7:0] OFF_FLAGS = 8'hE8;
   localparam logic [7:0] OFF_SEL   = 8'hE9;
   localparam logic [7:0] OFF_ISO   = 8'hEE;
   localparam logic [7:0] OFF_EN    = 8'hF0;
   localparam logic [7:0] OFF_DATA  = 8'hF1;
   localparam logic [7:0] OFF_COUNT = 8'hF2;
   localparam logic [7:0] OFF_SUM   = 8'hF4;

   // Flag register bit positions.
   localparam int BIT_BANK   = 7;
   localparam int BIT_NAKIN  = 6;
   localparam int BIT_RWAL   = 5;
   localparam int BIT_NAKOUT = 4;
   localparam int BIT_SETUP  = 3;
   localparam int BIT_OUTRX  = 2;
   localparam int BIT_STALL  = 1;
   localparam int BIT_TXRDY  = 0;

   // Enable register: bit 7 is the flow error enable, bit 5 is reserved.
   localparam int BIT_FLOWEN = 7;
   localparam logic [7:0] EN_MASK    = 8'hDF;
   localparam logic [7:0] FLAG_MASK  = 8'hDF;
   localparam logic [7:0] IRQ_MASK   = 8'h5F;
   localparam int         ISO_OVER   = 6;
   localparam int         ISO_UNDER  = 5;
   localparam logic [7:0] RST_BYTE   = 8'h00;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ueb_bus_t;

   typedef struct packed {
      logic [2:0] ep;
      logic       rx_valid;
      logic [7:0] rx_byte;
      logic       rx_end;
      logic       setup;
      logic       in_sent;
      logic       nak_in;
      logic       nak_out;
      logic       stall;
      logic       overflow;
      logic       underflow;
   } ueb_usb_evt_t;

   typedef struct packed {
      logic       send;
      logic       release_bank;
      logic [2:0] ep;
      logic [7:0] count;
   } ueb_hand_t;

   typedef struct packed {
      logic [7:0] flags;
      logic [1:0] iso;
      logic [7:0] en;
      logic [7:0] count;
      logic [7:0] rd_idx;
      logic       busy;
   } ueb_ep_t;

   typedef struct packed {
      ueb_ep_t [EP_NUM-1:0] ep;
      logic [2:0]           sel;
      logic [7:0]           rd_data;
      logic [7:0]           tx_byte;
      logic                 irq;
      logic [EP_NUM-1:0]    summary;
      ueb_hand_t            hand;
   } ueb_state_t;

endpackage

//--- hw/ueb_bank_store.sv
// Byte store holding one bank for every endpoint.
`timescale 1ns/10ps
module ueb_bank_store #(
   parameter int DEPTH = ueb_pkg::BANK_DEPTH,
   parameter int AW    = $clog2(ueb_pkg::EP_NUM * DEPTH)
) (
   input  wire logic          clock,
   input  wire logic          wa_en,
   input  wire logic [AW-1:0] wa_addr,
   input  wire logic [7:0]    wa_data,
   input  wire logic          wb_en,
   input  wire logic [AW-1:0] wb_addr,
   input  wire logic [7:0]    wb_data,
   input  wire logic [AW-1:0] ra_addr,
   output logic      [7:0]    ra_data,
   input  wire logic [AW-1:0] rb_addr,
   output logic      [7:0]    rb_data
);
   import ueb_pkg::*;

   logic [7:0] mem [EP_NUM*DEPTH];

   // Two write ports: the CPU fills IN banks, the controller fills OUT banks.
   always_ff @(posedge clock) begin
      if (wa_en) begin
         mem[wa_addr] <= wa_data;
      end
      if (wb_en) begin
         mem[wb_addr] <= wb_data;
      end
   end

   // Reads are combinational so the caller can register the byte itself.
   assign ra_data = mem[ra_addr];
   assign rb_data = mem[rb_addr];

endmodule

//--- hw/ueb_endpoint_regs.sv
// Endpoint flag, enable, data port, byte counter and summary registers.
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
module ueb_endpoint_regs #(
   parameter int BANK_DEPTH = ueb_pkg::BANK_DEPTH
) (
   input  wire logic                        clock,
   input  wire logic                        sys_rst,
   input  wire ueb_pkg::ueb_bus_t           bus,
   output logic      [7:0]                  rd_data,
   input  wire logic                        global_irq_en,
   input  wire logic [ueb_pkg::EP_NUM-1:0]  ep_is_in,
   input  wire ueb_pkg::ueb_usb_evt_t       usb_evt,
   input  wire logic [7:0]                  usb_rd_idx,
   output logic      [7:0]                  usb_tx_byte,
   output ueb_pkg::ueb_hand_t               hand_off,
   output logic                             ep_irq
);
   import ueb_pkg::*;

   localparam int         AW        = $clog2(EP_NUM * BANK_DEPTH);
   localparam logic [8:0] DEPTH_CNT = 9'(BANK_DEPTH);

   ueb_state_t      st_reg;
   ueb_state_t      st_next;
   logic            wa_en;
   logic [AW-1:0]   wa_addr;
   logic [7:0]      wa_data;
   logic            wb_en;
   logic [AW-1:0]   wb_addr;
   logic [AW-1:0]   ra_addr;
   logic [7:0]      ra_data;
   logic [AW-1:0]   rb_addr;
   logic [7:0]      rb_data;
   logic            sel_ok;

   // Flat store address of byte idx inside the bank of endpoint ep.
   function automatic logic [AW-1:0] bank_addr(input logic [2:0] ep,
                                               input logic [7:0] idx);
      return AW'(int'(ep) * BANK_DEPTH + int'(idx));
   endfunction

   // An endpoint asks for an interrupt when an enabled flag is set.
   function automatic logic ep_pending(input ueb_ep_t e);
      logic p;
      p = |(e.flags & e.en & IRQ_MASK);
      p = p | (e.en[BIT_FLOWEN] & (|e.iso));
      return p;
   endfunction

   // Any interrupt flag set, enabled or not, sets the endpoint's summary bit.
   function automatic logic ep_any_flag(input ueb_ep_t e);
      return (|(e.flags & IRQ_MASK)) | (|e.iso);
   endfunction

   // True when the bank may take one more byte.
   function automatic logic has_room(input logic [7:0] cnt);
      return {1'b0, cnt} < DEPTH_CNT;
   endfunction

   assign sel_ok = int'(st_reg.sel) < EP_NUM;

   ueb_bank_store #(
      .DEPTH (BANK_DEPTH),
      .AW    (AW)
   ) u_store (
      .clock   (clock),
      .wa_en   (wa_en),
      .wa_addr (wa_addr),
      .wa_data (wa_data),
      .wb_en   (wb_en),
      .wb_addr (wb_addr),
      .wb_data (usb_evt.rx_byte),
      .ra_addr (ra_addr),
      .ra_data (ra_data),
      .rb_addr (rb_addr),
      .rb_data (rb_data)
   );

   // Next state: CPU side first, then controller events, so a set that
   // lands in the same cycle as a software clear is never lost.
   always_comb begin
      logic       mine;
      logic       pop;
      logic [7:0] clr;
      logic [7:0] rv;
      st_next                   = st_reg;
      mine                      = 1'b0;
      pop                       = 1'b0;
      clr                       = 8'h00;
      rv                        = 8'h00;
      st_next.hand.send         = 1'b0;
      st_next.hand.release_bank = 1'b0;
      st_next.rd_data           = 8'h00;
      wa_en   = 1'b0;
      wa_data = bus.wdata;
      wa_addr = bank_addr(st_reg.sel, st_reg.ep[0].count);
      wb_en   = 1'b0;
      wb_addr = bank_addr(usb_evt.ep, st_reg.ep[0].count);
      ra_addr = bank_addr(st_reg.sel, st_reg.ep[0].rd_idx);
      rb_addr = bank_addr(usb_evt.ep, usb_rd_idx);
      st_next.tx_byte = rb_data;
      if (bus.wr && bus.addr == OFF_SEL) begin
         st_next.sel = bus.wdata[2:0];
      end
      for (int e = 0; e < EP_NUM; e++) begin
         mine = sel_ok && (st_reg.sel == 3'(e));
         if (mine) begin
            ra_addr = bank_addr(3'(e), st_reg.ep[e].rd_idx);
            wa_addr = bank_addr(3'(e), st_reg.ep[e].count);
         end
         if (mine && bus.wr) begin
            case (bus.addr)
               OFF_FLAGS: begin
                  // Zero acknowledges, one keeps the bit as it was.
                  clr = ~bus.wdata & FLAG_MASK;
                  if (clr[BIT_BANK] && st_reg.ep[e].flags[BIT_BANK]) begin
                     st_next.hand.ep = 3'(e);
                     st_next.ep[e].count  = RST_BYTE;
                     st_next.ep[e].rd_idx = RST_BYTE;
                     if (ep_is_in[e]) begin
                        st_next.hand.send  = 1'b1;
                        st_next.hand.count = st_reg.ep[e].count;
                        st_next.ep[e].busy = 1'b1;
                     end else begin
                        st_next.hand.release_bank = 1'b1;
                        st_next.hand.count        = RST_BYTE;
                        st_next.ep[e].busy        = 1'b0;
                     end
                  end
                  st_next.ep[e].flags = st_reg.ep[e].flags & ~clr;
               end
               OFF_ISO: begin
                  st_next.ep[e].iso = st_reg.ep[e].iso &
                     {bus.wdata[ISO_OVER], bus.wdata[ISO_UNDER]};
               end
               OFF_EN: begin
                  st_next.ep[e].en = bus.wdata & EN_MASK;
               end
               OFF_DATA: begin
                  // Loading is only allowed while the IN bank is ours.
                  if (ep_is_in[e] && !st_reg.ep[e].busy &&
                      has_room(st_reg.ep[e].count)) begin
                     wa_en = 1'b1;
                     st_next.ep[e].count =
                        st_reg.ep[e].count + 8'h01;
                  end
               end
               default: begin
                  // The counter and summary ignore writes.
               end
            endcase
         end
         // An OUT pop is legal only while the bank is handed to the CPU.
         if (mine && bus.rd && bus.addr == OFF_DATA && !ep_is_in[e] &&
             st_reg.ep[e].busy && st_reg.ep[e].count != 8'h00) begin
            pop = 1'b1;
            st_next.ep[e].count  = st_reg.ep[e].count - 8'h01;
            st_next.ep[e].rd_idx = st_reg.ep[e].rd_idx + 8'h01;
         end
         // Controller events for the endpoint it names.
         if (usb_evt.ep == 3'(e)) begin
            if (usb_evt.rx_valid && !ep_is_in[e] && !st_reg.ep[e].busy &&
                has_room(st_reg.ep[e].count)) begin
               wb_en   = 1'b1;
               wb_addr = bank_addr(3'(e), st_reg.ep[e].count);
               st_next.ep[e].count = st_reg.ep[e].count + 8'h01;
            end
            if (usb_evt.rx_end && !ep_is_in[e] && !st_reg.ep[e].busy) begin
               st_next.ep[e].busy            = 1'b1;
               st_next.ep[e].rd_idx          = RST_BYTE;
               st_next.ep[e].flags[BIT_BANK] = 1'b1;
               if (usb_evt.setup) begin
                  st_next.ep[e].flags[BIT_SETUP] = 1'b1;
               end else begin
                  st_next.ep[e].flags[BIT_OUTRX] = 1'b1;
               end
            end
            if (usb_evt.in_sent && ep_is_in[e] && st_reg.ep[e].busy) begin
               st_next.ep[e].busy = 1'b0;
            end
            if (usb_evt.nak_in) begin
               st_next.ep[e].flags[BIT_NAKIN] = 1'b1;
            end
            if (usb_evt.nak_out) begin
               st_next.ep[e].flags[BIT_NAKOUT] = 1'b1;
            end
            if (usb_evt.stall) begin
               st_next.ep[e].flags[BIT_STALL] = 1'b1;
            end
            if (usb_evt.overflow) begin
               st_next.ep[e].iso[1] = 1'b1;
            end
            if (usb_evt.underflow) begin
               st_next.ep[e].iso[0] = 1'b1;
            end
         end
         // A free IN bank not yet announced raises ready and the bank bit.
         if (ep_is_in[e] && !st_reg.ep[e].busy &&
             !st_reg.ep[e].flags[BIT_BANK] && !st_next.ep[e].busy) begin
            st_next.ep[e].flags[BIT_BANK]  = 1'b1;
            st_next.ep[e].flags[BIT_TXRDY] = 1'b1;
         end
         // Summary follows the flags, so serving them clears the bit.
         st_next.summary[e] = ep_any_flag(st_reg.ep[e]);
      end
      // The global flag gates the OR of every enabled source.
      st_next.irq = 1'b0;
      for (int e = 0; e < EP_NUM; e++) begin
         st_next.irq = st_next.irq | ep_pending(st_reg.ep[e]);
      end
      st_next.irq = st_next.irq & global_irq_en;
      // Read answer, valid only in the cycle after the strobe.
      if (bus.rd) begin
         case (bus.addr)
            OFF_SEL: rv = {5'b0_0000, st_reg.sel};
            OFF_SUM: rv = {3'b000, st_reg.summary};
            default: rv = 8'h00;
         endcase
         for (int e = 0; e < EP_NUM; e++) begin
            if (sel_ok && st_reg.sel == 3'(e)) begin
               case (bus.addr)
                  OFF_FLAGS: begin
                     rv = st_reg.ep[e].flags;
                     rv[BIT_RWAL] = ep_is_in[e] ?
                        (!st_reg.ep[e].busy && has_room(st_reg.ep[e].count))
                        : (st_reg.ep[e].busy && st_reg.ep[e].count != 8'h00);
                  end
                  OFF_ISO: begin
                     rv = 8'h00;
                     rv[ISO_OVER]  = st_reg.ep[e].iso[1];
                     rv[ISO_UNDER] = st_reg.ep[e].iso[0];
                  end
                  OFF_EN:    rv = st_reg.ep[e].en;
                  OFF_DATA:  rv = pop ? ra_data : 8'h00;
                  OFF_COUNT: rv = st_reg.ep[e].count;
                  default:   rv = rv;
               endcase
            end
         end
      end
      st_next.rd_data = rv;
   end

   // State register; everything clears on a synchronous reset.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs come straight from the state register.
   assign rd_data     = st_reg.rd_data;
   assign usb_tx_byte = st_reg.tx_byte;
   assign hand_off    = st_reg.hand;
   assign ep_irq      = st_reg.irq;

   // Helper views of the selected endpoint for the checks below.
   logic [7:0] sel_cnt;
   logic [7:0] sel_flags;
   logic       sel_in;
   logic       sel_busy;
   assign sel_cnt   = sel_ok ? st_reg.ep[st_reg.sel].count : 8'h00;
   assign sel_flags = sel_ok ? st_reg.ep[st_reg.sel].flags : 8'h00;
   assign sel_in    = sel_ok ? ep_is_in[st_reg.sel] : 1'b0;
   assign sel_busy  = sel_ok ? st_reg.ep[st_reg.sel].busy : 1'b0;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   // Endpoint 1 is the one the bench wires as IN, so this check fires.
   a_tx_ready_set: assert property (
      (usb_evt.in_sent && usb_evt.ep == 3'd1 && ep_is_in[1] &&
       st_reg.ep[1].busy && !(bus.wr && bus.addr == OFF_SEL))
      ##1 ep_is_in[1] |=> st_reg.ep[1].flags[BIT_TXRDY])
      else $error("Transmit-ready not set after bank freed.");

   a_ack_one_keeps: assert property (
      (bus.wr && bus.addr == OFF_FLAGS && bus.wdata[BIT_TXRDY] &&
       sel_flags[BIT_TXRDY]) |=> sel_flags[BIT_TXRDY])
      else $error("Writing one cleared transmit-ready.");

   a_flow_irq: assert property (
      (global_irq_en && st_reg.ep[0].en[BIT_FLOWEN] &&
       |st_reg.ep[0].iso) |=> ep_irq)
      else $error("Flow error did not raise the interrupt.");

   a_txrdy_irq: assert property (
      (global_irq_en && st_reg.ep[1].en[BIT_TXRDY] &&
       st_reg.ep[1].flags[BIT_TXRDY]) |=> ep_irq)
      else $error("Transmit-ready did not raise the interrupt.");

   a_global_gate: assert property (
      !global_irq_en |=> !ep_irq)
      else $error("Interrupt raised with global flag clear.");

   a_en_bit5: assert property (
      (bus.rd && bus.addr == OFF_EN) |=> !rd_data[5])
      else $error("Reserved enable bit read as one.");

   a_sum_top: assert property (
      (bus.rd && bus.addr == OFF_SUM) |=> rd_data[7:5] == 3'b000)
      else $error("Summary upper bits read as one.");

   a_cnt_ro: assert property (
      (bus.wr && bus.addr == OFF_COUNT && !usb_evt.rx_valid &&
       !usb_evt.rx_end) |=> sel_cnt == $past(sel_cnt))
      else $error("Counter changed on a software write.");

   a_cnt_inc: assert property (
      (bus.wr && bus.addr == OFF_DATA && sel_in && !sel_busy &&
       has_room(sel_cnt)) |=> sel_cnt == $past(sel_cnt) + 8'h01)
      else $error("IN counter did not step up by one.");

   a_cnt_dec: assert property (
      (bus.rd && bus.addr == OFF_DATA && sel_ok && !sel_in &&
       sel_busy && sel_cnt != 8'h00)
      |=> sel_cnt == $past(sel_cnt) - 8'h01 && rd_data == $past(ra_data))
      else $error("OUT counter did not step down by one.");

   a_out_flag_set: assert property (
      (usb_evt.rx_end && !usb_evt.setup && usb_evt.ep == 3'd2 &&
       !ep_is_in[2] && !st_reg.ep[2].busy) |=> st_reg.ep[2].flags[BIT_OUTRX])
      else $error("Received-OUT flag not set after packet end.");

   a_sum_pending: assert property (
      (|st_reg.ep[0].flags[4:0]) |=> st_reg.summary[0])
      else $error("Summary bit missing for a pending flag.");

   a_sum_served: assert property (
      (st_reg.ep[0].flags[6:0] == 7'h00 && st_reg.ep[0].iso == 2'b00)
      |=> !st_reg.summary[0])
      else $error("Summary bit stayed set after flags were served.");

   c_in_load: cover property (
      bus.wr && bus.addr == OFF_DATA && sel_in ##[1:200] hand_off.send);
   c_out_pop: cover property (
      usb_evt.rx_end ##[1:20] (bus.rd && bus.addr == OFF_DATA));
   c_irq: cover property (!ep_irq ##1 ep_irq);
   c_release: cover property (hand_off.release_bank);

endmodule

//--- verification/tb_ueb_endpoint_regs.sv
// Self-checking testbench for the endpoint register block.
`timescale 1ns/10ps
module tb_ueb_endpoint_regs;
   import ueb_pkg::*;

   logic               clock;
   logic               sys_rst;
   ueb_bus_t           bus;
   logic [7:0]         rd_data;
   logic               global_irq_en;
   logic [EP_NUM-1:0]  ep_is_in;
   ueb_usb_evt_t       evt;
   logic [7:0]         usb_rd_idx;
   logic [7:0]         usb_tx_byte;
   ueb_hand_t          hand_off;
   logic               ep_irq;
   int                 mismatches;
   int                 check_count;
   logic [7:0]         v;

   ueb_endpoint_regs dut_u (
      .clock         (clock),
      .sys_rst       (sys_rst),
      .bus           (bus),
      .rd_data       (rd_data),
      .global_irq_en (global_irq_en),
      .ep_is_in      (ep_is_in),
      .usb_evt       (evt),
      .usb_rd_idx    (usb_rd_idx),
      .usb_tx_byte   (usb_tx_byte),
      .hand_off      (hand_off),
      .ep_irq        (ep_irq)
   );

   // Free-running system clock, 20 ns period.
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // Compares one observed value against its expectation.
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints the verdict and stops the run.
   task automatic test_done();
      if (mismatches == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // One write cycle; the strobe drops at the edge that takes it.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      bus.wr <= 1'b0;
   endtask

   // One read cycle; read data is sampled in the single cycle it stands.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      bus.rd <= 1'b0;
      #1;
      d = rd_data;
   endtask

   // Sends one controller event pulse of kind k for endpoint e.
   task automatic ev(input logic [2:0] e, input int k, input logic [7:0] b);
      ueb_usb_evt_t t;
      ueb_usb_evt_t idle;
      idle = '0;
      idle.ep = e;
      t = idle;
      case (k)
         0: t.nak_in = 1'b1;
         1: t.nak_out = 1'b1;
         2: t.stall = 1'b1;
         3: t.overflow = 1'b1;
         4: t.underflow = 1'b1;
         5: begin
            t.rx_end = 1'b1;
            t.setup  = 1'b1;
         end
         6: begin
            t.rx_valid = 1'b1;
            t.rx_byte  = b;
         end
         7: t.rx_end = 1'b1;
         default: t.in_sent = 1'b1;
      endcase
      @(posedge clock);
      evt <= t;
      @(posedge clock);
      evt <= idle;
   endtask

   // IN endpoint: fill, count, read-only counter, tx-ready, send, ready again.
   task automatic test_in();
      wr(OFF_SEL, 8'h01);
      rd(OFF_FLAGS, v);
      chk(v & 8'h81, 8'h81);
      wr(OFF_DATA, 8'h11);
      wr(OFF_DATA, 8'h22);
      wr(OFF_DATA, 8'h33);
      rd(OFF_COUNT, v);
      chk(v, 8'h03);
      wr(OFF_COUNT, 8'hFF);
      rd(OFF_COUNT, v);
      chk(v, 8'h03);
      wr(OFF_EN, 8'hFF);
      rd(OFF_EN, v);
      chk(v, 8'hDF);
      wr(OFF_EN, 8'h01);
      global_irq_en <= 1'b1;
      repeat (3) @(posedge clock);
      chk(ep_irq, 1'b1);
      wr(OFF_FLAGS, 8'hFE);
      repeat (2) @(posedge clock);
      chk(ep_irq, 1'b0);
      rd(OFF_FLAGS, v);
      chk(v & 8'h81, 8'h80);
      global_irq_en <= 1'b0;
      wr(OFF_FLAGS, 8'h7F);
      #1;
      chk(hand_off.send, 1'b1);
      chk(hand_off.count, 8'h03);
      // The controller fetches from the bank of the endpoint it names.
      evt.ep     <= 3'd1;
      usb_rd_idx <= 8'h01;
      repeat (2) @(posedge clock);
      #1;
      chk(usb_tx_byte, 8'h22);
      ev(3'd1, 8, 8'h00);
      repeat (3) @(posedge clock);
      rd(OFF_FLAGS, v);
      chk(v & 8'h81, 8'h81);
      wr(OFF_FLAGS, 8'hFF);
      rd(OFF_FLAGS, v);
      chk(v & 8'h81, 8'h81);
      // Mask endpoint 1 so its standing ready flag stays quiet later.
      wr(OFF_EN, 8'h00);
   endtask

   // OUT endpoint: receive two bytes, pop them, summary set and cleared.
   task automatic test_out();
      ev(3'd2, 6, 8'hA5);
      ev(3'd2, 6, 8'h5A);
      ev(3'd2, 7, 8'h00);
      wr(OFF_SEL, 8'h02);
      rd(OFF_FLAGS, v);
      chk(v & 8'h84, 8'h84);
      rd(OFF_COUNT, v);
      chk(v, 8'h02);
      rd(OFF_DATA, v);
      chk(v, 8'hA5);
      rd(OFF_COUNT, v);
      chk(v, 8'h01);
      rd(OFF_DATA, v);
      chk(v, 8'h5A);
      rd(OFF_SUM, v);
      chk(v & 8'hE4, 8'h04);
      wr(OFF_FLAGS, 8'hFB);
      repeat (2) @(posedge clock);
      rd(OFF_SUM, v);
      chk(v & 8'h04, 8'h00);
      wr(OFF_FLAGS, 8'h7F);
      #1;
      chk(hand_off.release_bank, 1'b1);
      chk(hand_off.count, 8'h00);
      rd(OFF_COUNT, v);
      chk(v, 8'h00);
      rd(8'h10, v);
      chk(v, 8'h00);
   endtask

   // Six event flags on endpoint 0 against their enable bits; the two flow errors share bit 7.
   task automatic test_irq();
      logic [7:0] en_b [6];
      logic [7:0] cl_a [6];
      logic [7:0] cl_d [6];
      en_b = '{8'h40, 8'h10, 8'h02, 8'h80, 8'h80, 8'h08};
      cl_a = '{OFF_FLAGS, OFF_FLAGS, OFF_FLAGS, OFF_ISO, OFF_ISO, OFF_FLAGS};
      cl_d = '{8'hBF, 8'hEF, 8'hFD, 8'hBF, 8'hDF, 8'hF7};
      wr(OFF_SEL, 8'h00);
      for (int i = 0; i < 6; i++) begin
         wr(OFF_EN, ~en_b[i] & 8'hDF);
         global_irq_en <= 1'b1;
         ev(3'd0, i, 8'h00);
         repeat (2) @(posedge clock);
         chk(ep_irq, 1'b0);
         wr(OFF_EN, en_b[i]);
         repeat (2) @(posedge clock);
         chk(ep_irq, 1'b1);
         global_irq_en <= 1'b0;
         repeat (2) @(posedge clock);
         chk(ep_irq, 1'b0);
         rd(OFF_SUM, v);
         chk(v & 8'h01, 8'h01);
         wr(cl_a[i], cl_d[i]);
         repeat (2) @(posedge clock);
         rd(OFF_SUM, v);
         chk(v & 8'h01, 8'h00);
      end
   endtask

   // Main sequence: reset for six cycles, then the scenarios.
   initial begin
      mismatches = 0;
      check_count = 0;
      sys_rst = 1'b1;
      bus = '0;
      global_irq_en = 1'b0;
      ep_is_in = 5'b00010;
      evt = '0;
      usb_rd_idx = 8'h00;
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clock);
      test_in();
      test_out();
      test_irq();
      test_done();
   end

   // Cuts a hung run short well after the scenarios should have ended.
   initial begin
      #200000;
      mismatches++;
      test_done();
   end
endmodule
